// file: inc/mtc_pkg.sv
// ****************************************************************
// Shared constants and carriers for the multichannel timer core
// ****************************************************************
package mtc_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NCH = 6;        // Channels
   localparam int CNT_W = 16;     // Counter and general register width
   localparam int NGR = 4;        // General registers A..D per slot
   localparam int ADR_W = 8;      // Wishbone byte address width
   localparam int CH_SHIFT = 5;   // Channel block stride is 32 bytes

   // ************************************************************
   // Byte offsets inside a channel block, and global registers
   // ************************************************************
   localparam logic [2:0] WRD_CTRL = 3'h0;  // Offset 0x00, counter ctrl
   localparam logic [2:0] WRD_PINC = 3'h1;  // Offset 0x04, pin control
   localparam logic [2:0] WRD_STAT = 3'h2;  // Offset 0x08, status flags
   localparam logic [2:0] WRD_CNT = 3'h3;   // Offset 0x0c, counter
   localparam logic [2:0] WRD_GRA = 3'h4;   // Offsets 0x10..0x1c, A..D
   localparam logic [ADR_W-1:0] ADR_RUN = 8'hc0;   // Run control
   localparam logic [ADR_W-1:0] ADR_SYNC = 8'hc4;  // Sync select

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CSEL_LSB = 0;     // Clear select, 3 bits
   localparam int BUF_AC_BIT = 4;   // C buffers A (channels 0, 3)
   localparam int BUF_BD_BIT = 5;   // D buffers B (channels 0, 3)
   localparam int CAP_LSB = 0;      // Pin control: capture mode A..D
   localparam int ACT_A_LSB = 8;    // Pin control: match action pin A
   localparam int ACT_B_LSB = 10;   // Pin control: match action pin B
   localparam int INIT_A_BIT = 12;  // Pin control: initial level A
   localparam int INIT_B_BIT = 13;  // Pin control: initial level B

   // ************************************************************
   // Codes
   // ************************************************************
   localparam logic [2:0] CSEL_NONE = 3'h0;  // No counter clear
   localparam logic [2:0] CSEL_A = 3'h1;     // Clear on A event
   localparam logic [2:0] CSEL_B = 3'h2;     // Clear on B event
   localparam logic [2:0] CSEL_SYNC = 3'h3;  // Synchronous clear
   localparam logic [1:0] ACT_NONE = 2'h0;   // Pin untouched
   localparam logic [1:0] ACT_LOW = 2'h1;    // Drive 0 on match
   localparam logic [1:0] ACT_HIGH = 2'h2;   // Drive 1 on match
   localparam logic [1:0] ACT_TOGGLE = 2'h3; // Toggle on match

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] GR_RST = 16'hffff;
   localparam logic [NCH-1:0] RUN_RST = 6'h00;
   localparam logic [NCH-1:0] SYNC_RST = 6'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] PINC_RST = 16'h0000;
   localparam logic [NGR-1:0] FLAG_RST = 4'h0;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic tick;              // Selected count clock edge
      logic [NGR-1:0] cap;     // Capture strobes for A..D
   } mtc_evt_s;

   typedef struct packed {
      logic [NGR-1:0] clr;     // Transfer served flag A..D
      logic transfer_disable_select;             // Transfer disable select bit
   } mtc_xfer_s;

   typedef struct packed {
      logic [1:0] lvl;         // Pin levels A, B
      logic [1:0] oe_n;        // Low while the pin is driven
   } mtc_pin_s;

endpackage

// file: hw/mtc_counter.sv
`timescale 1ns/1ns
// ****************************************************************
// One channel up-counter
// ****************************************************************
module mtc_counter #(
   parameter int W = 16                  // Counter width
) (
   input wire logic mclk_i,              // Core clock
   input wire logic srst_i,              // Sync reset, high
   input wire logic zero_i,              // Standby hold at zero
   input wire logic load_i,              // Bus preset strobe
   input wire logic [W-1:0] load_val_i,  // Preset value
   input wire logic clr_i,               // Counter clear event
   input wire logic run_i,               // Run bit
   input wire logic tick_i,              // Count clock edge
   output logic [W-1:0] cnt_o            // Present count
);
   import mtc_pkg::*;

   logic [W-1:0] cnt_q;  // Count register
   logic [W-1:0] cnt_d;  // Next count

   // ************************************************************
   // Next count
   // ************************************************************
   // Preset beats clear so software sees its own write; standby zero beats both
   always_comb begin
      cnt_d = cnt_q;
      if (zero_i) begin
         cnt_d = '0;
      end else if (load_i) begin
         cnt_d = load_val_i;
      end else if (clr_i) begin
         cnt_d = '0;
      end else if (run_i && tick_i) begin
         cnt_d = cnt_q + W'(1);
      end
   end

   // Register stage
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cnt_q <= W'(CNT_RST);
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign cnt_o = cnt_q;

endmodule

// file: hw/mtc_timer_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Compare match sets the flag of its register A..D
// - Capture copies counter, sets the flag of its register A..D
// - Flag clears by zero-write after read-one
// - Transfer with disable-select zero clears flag
// - Six sixteen-bit readable writable up-counters
// - Counters zero on reset and standby
// - Sixteen general registers: four, two per channel
// - General registers compare or capture, read/write
// - Channels 0, 3: C buffers A, D buffers B
// - Run bits 5..0 stop or start counters
// - Stopping keeps present compare output level
// - Pin control write while stopped sets initial
// - Sync bit selects synchronous mode, default 0
// - Sync channels preset together, clear together
// - C, D flags reserved on other channels
module mtc_timer_core (
   input wire logic mclk_i,                          // Core clock
   input wire logic srst_i,                          // Sync reset, high
   input wire logic standby_i,                       // Hardware standby
   input wire logic wb_cyc_i,                        // Bus cycle
   input wire logic wb_stb_i,                        // Bus strobe
   input wire logic wb_we_i,                         // Write enable
   input wire logic [mtc_pkg::ADR_W-1:0] wb_adr_i,   // Byte address
   input wire logic [3:0] wb_sel_i,                  // Byte lanes
   input wire logic [31:0] wb_dat_i,                 // Write data
   output logic [31:0] wb_dat_o,                     // Read data
   output logic wb_ack_o,                            // Acknowledge
   input mtc_pkg::mtc_evt_s [mtc_pkg::NCH-1:0] evt_i,   // Ticks, captures
   input mtc_pkg::mtc_xfer_s [mtc_pkg::NCH-1:0] xfer_i, // Transfer done
   output logic [mtc_pkg::NCH-1:0][mtc_pkg::NGR-1:0] flag_o, // Flags
   output mtc_pkg::mtc_pin_s [mtc_pkg::NCH-1:0] pin_o   // Timer pins
);
   import mtc_pkg::*;

   // ************************************************************
   // Bus slave
   // ************************************************************
   logic ack_q;              // Ack register
   logic ack_d;              // Next ack
   logic [31:0] rdat_q;      // Read data register
   logic [31:0] rdat_d;      // Next read data
   logic commit;             // Edge where the access takes effect
   logic wr;                 // Committed write
   logic rd;                 // Committed read
   logic [2:0] ch_idx;       // Channel block index
   logic [2:0] wrd_idx;      // Word inside the block
   logic ch_hit;             // Address falls in a channel block
   logic sel16;              // Both low lanes enabled
   logic sel8;               // Low lane enabled

   assign commit = wb_cyc_i & wb_stb_i & ack_q;
   assign wr = commit & wb_we_i;
   assign rd = commit & ~wb_we_i;
   assign ch_idx = wb_adr_i[ADR_W-1:CH_SHIFT];
   assign wrd_idx = wb_adr_i[CH_SHIFT-1:2];
   assign ch_hit = (ch_idx < 3'(NCH));
   // Byte writes to 16-bit registers are dropped whole
   assign sel16 = (wb_sel_i[1:0] == 2'b11);
   assign sel8 = wb_sel_i[0];

   // ************************************************************
   // Control and channel state
   // ************************************************************
   logic [NCH-1:0] run_q, run_d;          // counter_run_ctrl
   logic [NCH-1:0] sync_q, sync_d;        // chan_sync_select
   logic [7:0] ctrl_q [NCH];              // counter_control_reg
   logic [15:0] pinc_q [NCH];             // pin_control_reg
   logic [NGR-1:0] flag_q [NCH];          // chan_status_flags
   logic [NGR-1:0] arm_q [NCH];           // Flags seen as one
   logic [CNT_W-1:0] gr_q [NCH][NGR];     // general_cmp_cap
   logic [1:0] pin_q [NCH];               // Pin levels A, B
   logic [CNT_W-1:0] cnt [NCH];           // chan_counter values
   logic [NCH-1:0] own_clr;               // Own clear event
   logic [NCH-1:0] cnt_wr;                // Counter write per channel
   logic sync_clr_any;                    // Clear by a sync channel
   logic sync_pre_any;                    // Preset to a sync channel

   // Counter write decode, one-hot over channels
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         cnt_wr[c] = wr & sel16 & ch_hit & (ch_idx == 3'(c))
                     & (wrd_idx == WRD_CNT);
      end
   end

   // Any sync channel cleared or preset this cycle
   assign sync_clr_any = |(own_clr & sync_q);
   assign sync_pre_any = |(cnt_wr & sync_q);

   // ************************************************************
   // Global registers and bus answer
   // ************************************************************
   // Reserved bits 7, 6 are stored nowhere and read zero
   always_comb begin
      run_d = run_q;
      sync_d = sync_q;
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      if (wr && sel8 && (wb_adr_i == ADR_RUN)) begin
         run_d = wb_dat_i[NCH-1:0];
      end
      if (wr && sel8 && (wb_adr_i == ADR_SYNC)) begin
         sync_d = wb_dat_i[NCH-1:0];
      end
   end

   // Read data captured in the request cycle, shown with ack
   always_comb begin
      rdat_d = rdat_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
         rdat_d = '0;                    // Unmapped reads zero
         if (wb_adr_i == ADR_RUN) begin
            rdat_d[NCH-1:0] = run_q;
         end else if (wb_adr_i == ADR_SYNC) begin
            rdat_d[NCH-1:0] = sync_q;
         end else if (ch_hit) begin
            unique case (wrd_idx)
               WRD_CTRL: rdat_d[7:0] = ctrl_q[ch_idx];
               WRD_PINC: rdat_d[15:0] = pinc_q[ch_idx];
               WRD_STAT: rdat_d[NGR-1:0] = flag_q[ch_idx];
               WRD_CNT: rdat_d[CNT_W-1:0] = cnt[ch_idx];
               // C and D exist on channels 0 and 3 only
               default: begin
                  if (!wrd_idx[1] || (ch_idx == 3'h0)
                      || (ch_idx == 3'h3)) begin
                     rdat_d[CNT_W-1:0] =
                        gr_q[ch_idx][2'(wrd_idx - WRD_GRA)];
                  end
               end
            endcase
         end
      end
   end

   // Register stage for global state
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         run_q <= RUN_RST;
         sync_q <= SYNC_RST;
         ack_q <= 1'b0;
         rdat_q <= '0;
      end else begin
         run_q <= run_d;
         sync_q <= sync_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ************************************************************
   // Per-channel logic
   // ************************************************************
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      // Only channels 0 and 3 own registers C and D
      localparam logic [NGR-1:0] VALID = ((c == 0) || (c == 3)) ?
                                         4'hf : 4'h3;
      logic sel_me;                  // Bus targets this channel
      logic [NGR-1:0] cap_mode;      // Register set for capture
      logic [NGR-1:0] active;        // Register not used as buffer
      logic [NGR-1:0] match;         // Compare match events
      logic [NGR-1:0] capt;          // Capture events
      logic [NGR-1:0] hw_set;        // Flag set events
      logic [NGR-1:0] clr_sw;        // Software flag clear
      logic [NGR-1:0] clr_hw;        // Transfer flag clear
      logic buf_ac, buf_bd;          // Buffer pairing enables
      logic [2:0] csel;              // Clear select field
      logic cnt_clr;                 // Counter clear this cycle
      logic [7:0] ctrl_d;            // Next control
      logic [15:0] pinc_d;           // Next pin control
      logic [NGR-1:0] flag_d;        // Next flags
      logic [NGR-1:0] arm_d;         // Next read arming
      logic [CNT_W-1:0] gr_d [NGR];  // Next general registers
      logic [1:0] pin_d;             // Next pin levels
      logic [1:0] act [2];           // Match actions for pins A, B

      assign sel_me = ch_hit & (ch_idx == 3'(c));
      assign csel = ctrl_q[c][CSEL_LSB +: 3];
      assign buf_ac = ctrl_q[c][BUF_AC_BIT] & VALID[2];
      assign buf_bd = ctrl_q[c][BUF_BD_BIT] & VALID[3];
      assign cap_mode = pinc_q[c][CAP_LSB +: NGR];
      assign active = VALID & ~{buf_bd, buf_ac, 2'b00};
      assign act[0] = pinc_q[c][ACT_A_LSB +: 2];
      assign act[1] = pinc_q[c][ACT_B_LSB +: 2];

      // Match and capture events
      // Match is judged only on a count edge of a running counter
      always_comb begin
         for (int k = 0; k < NGR; k++) begin
            match[k] = active[k] & ~cap_mode[k] & run_q[c]
                       & evt_i[c].tick & (cnt[c] == gr_q[c][k]);
            capt[k] = active[k] & cap_mode[k] & evt_i[c].cap[k];
         end
         hw_set = match | capt;
      end

      // Counter clear: own source, or sync clear from a partner
      assign own_clr[c] = ((csel == CSEL_A) & hw_set[0])
                        | ((csel == CSEL_B) & hw_set[1]);
      assign cnt_clr = own_clr[c] | (sync_q[c] & (csel == CSEL_SYNC)
                       & sync_clr_any);

      // Flag clear sources
      always_comb begin
         clr_sw = '0;
         if (wr && sel8 && sel_me && (wrd_idx == WRD_STAT)) begin
            clr_sw = arm_q[c] & ~wb_dat_i[NGR-1:0];
         end
         clr_hw = xfer_i[c].transfer_disable_select ? '0 : xfer_i[c].clr;
      end

      // Flags and read arming; a new event wins over any clear
      always_comb begin
         flag_d = ((flag_q[c] & ~clr_sw & ~clr_hw) | hw_set)
                  & VALID;
         arm_d = arm_q[c] & flag_d;
         if (rd && sel_me && (wrd_idx == WRD_STAT)) begin
            arm_d = arm_d | flag_q[c];
         end
      end

      // Control, pin control and general registers
      always_comb begin
         ctrl_d = ctrl_q[c];
         pinc_d = pinc_q[c];
         for (int k = 0; k < NGR; k++) begin
            gr_d[k] = gr_q[c][k];
         end
         if (wr && sel8 && sel_me && (wrd_idx == WRD_CTRL)) begin
            ctrl_d = wb_dat_i[7:0] & {2'b00, VALID[3], VALID[2], 4'hf};
         end
         if (wr && sel16 && sel_me && (wrd_idx == WRD_PINC)) begin
            pinc_d = wb_dat_i[15:0];
         end
         for (int k = 0; k < NGR; k++) begin
            if (wr && sel16 && sel_me && VALID[k]
                && (wrd_idx == WRD_GRA + 3'(k))) begin
               gr_d[k] = wb_dat_i[CNT_W-1:0];
            end
         end
         // Hardware transfers take priority over a bus write
         for (int k = 0; k < 2; k++) begin
            if (capt[k]) begin
               gr_d[k] = cnt[c];
            end else if (match[k] && (k == 0 ? buf_ac : buf_bd)) begin
               gr_d[k] = gr_q[c][k + 2];
            end
            if (capt[k] && (k == 0 ? buf_ac : buf_bd)) begin
               gr_d[k + 2] = gr_q[c][k];
            end
         end
         for (int k = 2; k < NGR; k++) begin
            if (capt[k]) begin
               gr_d[k] = cnt[c];
            end
         end
      end

      // Pin levels; a stopped counter makes no matches, so it holds
      always_comb begin
         pin_d = pin_q[c];
         for (int k = 0; k < 2; k++) begin
            if (match[k]) begin
               unique case (act[k])
                  ACT_NONE: pin_d[k] = pin_q[c][k];
                  ACT_LOW: pin_d[k] = 1'b0;
                  ACT_HIGH: pin_d[k] = 1'b1;
                  ACT_TOGGLE: pin_d[k] = ~pin_q[c][k];
               endcase
            end
         end
         if (wr && sel16 && sel_me && (wrd_idx == WRD_PINC)
             && !run_q[c]) begin
            pin_d = {wb_dat_i[INIT_B_BIT], wb_dat_i[INIT_A_BIT]};
         end
      end

      // Register stage for the channel
      always_ff @(posedge mclk_i) begin
         if (srst_i) begin
            ctrl_q[c] <= CTRL_RST;
            pinc_q[c] <= PINC_RST;
            flag_q[c] <= FLAG_RST;
            arm_q[c] <= FLAG_RST;
            pin_q[c] <= 2'b00;
            for (int k = 0; k < NGR; k++) begin
               gr_q[c][k] <= GR_RST;
            end
         end else begin
            ctrl_q[c] <= ctrl_d;
            pinc_q[c] <= pinc_d;
            flag_q[c] <= flag_d;
            arm_q[c] <= arm_d;
            pin_q[c] <= pin_d;
            for (int k = 0; k < NGR; k++) begin
               gr_q[c][k] <= gr_d[k];
            end
         end
      end

      // Counter; a sync preset copies the written value to every sync channel
      mtc_counter #(
         .W(CNT_W)
      ) u_cnt (
         .mclk_i(mclk_i),
         .srst_i(srst_i),
         .zero_i(standby_i),
         .load_i(cnt_wr[c] | (sync_q[c] & sync_pre_any)),
         .load_val_i(wb_dat_i[CNT_W-1:0]),
         .clr_i(cnt_clr),
         .run_i(run_q[c]),
         .tick_i(evt_i[c].tick),
         .cnt_o(cnt[c])
      );

      // Outputs from flip-flops; pin driven when set for compare with a match action other than ACT_NONE
      assign flag_o[c] = flag_q[c];
      assign pin_o[c].lvl = pin_q[c];
      assign pin_o[c].oe_n[0] = cap_mode[0] | (act[0] == ACT_NONE);
      assign pin_o[c].oe_n[1] = cap_mode[1] | (act[1] == ACT_NONE);
   end

endmodule

// file: sim/mtc_timer_core_properties.sv
`timescale 1ns/1ns
// ****************************************************************
// Port-level checks of the timer core
// ****************************************************************
module mtc_timer_core_properties (
   input wire logic mclk_i,                        // Clock
   input wire logic srst_i,                        // Reset
   input wire logic standby_i,                     // Standby
   input wire logic wb_cyc_i,                      // Bus cycle
   input wire logic wb_stb_i,                      // Bus strobe
   input wire logic wb_we_i,                       // Write enable
   input wire logic [mtc_pkg::ADR_W-1:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i,                // Byte lanes
   input wire logic [31:0] wb_dat_i,               // Write data
   input wire logic [31:0] wb_dat_o,               // Read data
   input wire logic wb_ack_o,                      // Acknowledge
   input mtc_pkg::mtc_evt_s [mtc_pkg::NCH-1:0] evt_i,   // Events
   input mtc_pkg::mtc_xfer_s [mtc_pkg::NCH-1:0] xfer_i, // Transfers
   input wire logic [mtc_pkg::NCH-1:0][mtc_pkg::NGR-1:0] flag_o, // Flags
   input mtc_pkg::mtc_pin_s [mtc_pkg::NCH-1:0] pin_o    // Pins
);
   import mtc_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // Fresh request, then a single-cycle answer
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_bus_answer: assert property (s_req |=> s_answer)
      else $error("bus request not answered in one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("ack without request");
   // Reserved flag bits never move
   a_cd_reserved: assert property ({flag_o[1][3:2], flag_o[2][3:2],
      flag_o[4][3:2], flag_o[5][3:2]} == 8'h00)
      else $error("reserved flag bit set");
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      // A flag only rises after an event of its own channel
      a_flag_set: assert property (
         (flag_o[g] & ~$past(flag_o[g])) != 0
         |-> $past(evt_i[g]) != 5'h00)
         else $error("flag set without event");
      // A flag only falls after a bus write or a served transfer
      a_flag_clear: assert property (
         (~flag_o[g] & $past(flag_o[g])) != 0
         |-> ($past(wb_ack_o) && $past(wb_we_i)) ||
         ($past(xfer_i[g].clr) != 0 && !$past(xfer_i[g].transfer_disable_select)))
         else $error("flag cleared without cause");
      // Writing ones over set flags leaves them set
      a_flag_keep: assert property (wb_ack_o && wb_we_i &&
         wb_adr_i == 8'(g * 32 + 8) && xfer_i[g].clr == 4'h0 &&
         (wb_dat_i[3:0] & flag_o[g]) == flag_o[g]
         |=> (flag_o[g] & $past(flag_o[g])) == $past(flag_o[g]))
         else $error("flag lost on write of one");
      // Pin level moves on a tick or an acknowledged bus access only
      a_pin_cause: assert property ($changed(pin_o[g].lvl)
         |-> $past(evt_i[g].tick) || $past(wb_ack_o))
         else $error("pin level changed without cause");
      a_oe_cause: assert property ($changed(pin_o[g].oe_n)
         |-> $past(wb_ack_o) && $past(wb_we_i))
         else $error("pin enable changed without write");
   end
endmodule
bind mtc_timer_core mtc_timer_core_properties i_props (
   .mclk_i, .srst_i, .standby_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .evt_i,
   .xfer_i, .flag_o, .pin_o);

// file: sim/mtc_timer_core_tb.sv
`timescale 1ns/1ns
// ****************************************************************
// Register-level bench of the timer core
// ****************************************************************
module mtc_timer_core_tb;
   import mtc_pkg::*;
   logic mclk_i, srst_i, standby_i;  // Clock, reset, standby
   logic cyc, stb, we, ack;          // Bus controls
   logic [7:0] adr;                  // Byte address
   logic [31:0] wdat, rd, rdat, v;   // Bus data
   mtc_evt_s [NCH-1:0] evt;          // Ticks and captures
   mtc_xfer_s [NCH-1:0] xfer;        // Transfer clears
   logic [NCH-1:0][NGR-1:0] flag;    // Flags
   mtc_pin_s [NCH-1:0] pin;          // Pins
   int error_cnt = 0;
   int n_compared = 0;
   int c, k;
   mtc_timer_core i_dut (.mclk_i(mclk_i), .srst_i(srst_i),
      .standby_i(standby_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rd), .wb_ack_o(ack), .evt_i(evt), .xfer_i(xfer),
      .flag_o(flag), .pin_o(pin));
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   task automatic complete_run();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One classic cycle; a missing ack ends the run
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         error_cnt++;
         complete_run();
      end
      rdat = rd;
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(nm, rdat, e);
   endtask
   // One-cycle event and transfer strobes
   task automatic pulse(input logic [29:0] e, x);
      @(posedge mclk_i);
      evt <= e;
      xfer <= x;
      @(posedge mclk_i);
      evt <= '0;
      xfer <= '0;
   endtask
   // Pins settle one edge after their cause
   task automatic pchk(input int ch, input logic [3:0] e);
      repeat (2) @(posedge mclk_i);
      check("pin", {28'h0, pin[ch]}, {28'h0, e});
   endtask
   function automatic logic [7:0] ra(input int ch, w);
      return 8'(ch * 32 + w * 4);
   endfunction
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {srst_i, standby_i, cyc, stb, we, adr, wdat} = {1'b1, 44'h0};
      evt = '0;
      xfer = '0;
      repeat (10) @(posedge mclk_i);
      srst_i <= 1'b0;
      rchk("sync", ADR_SYNC, 32'h0);
      for (c = 0; c < NCH; c++) begin
         rchk("cnt", ra(c, 3), 32'h0);
         rchk("stat", ra(c, 2), 32'h0);
         for (k = 0; k < NGR; k++) begin
            v = 32'h5a5aa500 + 32'(c * 16 + k);
            wr(ra(c, 4 + k), v);
            rchk("gr", ra(c, 4 + k),
                 (k < 2 || c % 3 == 0) ? v & 32'hffff : 32'h0);
         end
      end
      // Reserved run bits are only ever written as zero
      wr(ADR_RUN, 32'h3f);
      rchk("run", ADR_RUN, 32'h3f);
      wr(ADR_RUN, 32'h0);
      wr(ra(1, 3), 32'hfffe);
      wr(ADR_RUN, 32'h02);
      repeat (3) pulse({6{5'h10}}, 30'h0);
      rchk("wrap", ra(1, 3), 32'h1);
      rchk("stopped", ra(2, 3), 32'h0);
      wr(ADR_RUN, 32'h0);
      pulse({6{5'h10}}, 30'h0);
      rchk("halt", ra(1, 3), 32'h1);
      wr(ra(1, 4), 32'h5);
      wr(ra(1, 3), 32'h5);
      wr(ADR_RUN, 32'h02);
      pulse(30'h10 << 5, 30'h0);
      wr(ADR_RUN, 32'h0);
      wr(ra(1, 2), 32'h0);
      check("flag", {28'h0, flag[1]}, 32'h1);
      rchk("match", ra(1, 2), 32'h1);
      wr(ra(1, 2), 32'h1);
      rchk("one", ra(1, 2), 32'h1);
      wr(ra(1, 2), 32'h0);
      rchk("zero", ra(1, 2), 32'h0);
      wr(ra(0, 1), 32'h2);
      wr(ra(0, 3), 32'h0123);
      pulse(30'h02, 30'h0);
      rchk("capture", ra(0, 5), 32'h0123);
      rchk("cap flag", ra(0, 2), 32'h2);
      pulse(30'h0, 30'h05);
      rchk("transfer_disable_select", ra(0, 2), 32'h2);
      pulse(30'h0, 30'h04);
      rchk("served", ra(0, 2), 32'h0);
      // Capture set for C, so only the reservation keeps the flag low
      wr(ra(1, 1), 32'h4);
      pulse(30'h04 << 5, 30'h0);
      rchk("reserved", ra(1, 2), 32'h0);
      wr(ra(3, 0), 32'h10);
      wr(ra(3, 3), 32'ha530);
      wr(ADR_RUN, 32'h08);
      pulse(30'h10 << 15, 30'h0);
      wr(ADR_RUN, 32'h0);
      rchk("buffer", ra(3, 4), 32'ha532);
      wr(ra(2, 1), 32'h1100);
      pchk(2, 4'h6);
      wr(ra(2, 4), 32'h3);
      wr(ra(2, 3), 32'h3);
      wr(ADR_RUN, 32'h04);
      pulse(30'h10 << 10, 30'h0);
      wr(ADR_RUN, 32'h0);
      pchk(2, 4'h2);
      wr(ra(2, 1), 32'h1100);
      pchk(2, 4'h6);
      wr(ADR_SYNC, 32'h30);
      wr(ra(4, 3), 32'h77);
      rchk("preset", ra(5, 3), 32'h77);
      rchk("alone", ra(0, 3), 32'h0123);
      wr(ra(4, 0), 32'h1);
      wr(ra(5, 0), 32'h3);
      wr(ra(4, 4), 32'h77);
      wr(ADR_RUN, 32'h30);
      pulse((30'h10 << 20) | (30'h10 << 25), 30'h0);
      wr(ADR_RUN, 32'h0);
      rchk("own clear", ra(4, 3), 32'h0);
      rchk("sync clear", ra(5, 3), 32'h0);
      wr(ra(4, 3), 32'h55);
      standby_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      standby_i <= 1'b0;
      rchk("standby", ra(4, 3), 32'h0);
      rchk("unmapped", 8'he0, 32'h0);
      complete_run();
   end
endmodule
